// *** dma6_params.svh ***
/*
  numeric constants of the six-channel peripheral dma engine: register map,
  control bit positions, access lengths, address steps and the unmapped read value.
  assumes it is included by bare name, before the package and modules.
*/
`ifndef DMA6_PARAMS_SVH
`define DMA6_PARAMS_SVH

// ****************************************
// sizes
// ****************************************
`define NUM_CHANNELS 6
`define TRIG_SOURCES 8

// ****************************************
// register map, byte addresses
// ****************************************
`define CH_STRIDE 8'h10
`define OFS_PIO_ADDR 8'h00
`define OFS_RAM_ADDR 8'h04
`define OFS_COUNT 8'h08
`define OFS_CTRL 8'h0c
`define OFS_TRIG_EXP 8'h60
`define OFS_IRQ_STATUS 8'h64
`define OFS_IRQ_MASK 8'h68

// ****************************************
// channel control register bits
// ****************************************
`define CTRL_TC 7
`define CTRL_HOLD 5
`define CTRL_TTYP_HI 4
`define CTRL_TTYP_LO 3
`define CTRL_DIR 2
`define CTRL_SIZE 1
`define CTRL_EN 0

// ****************************************
// access lengths and steps
// ****************************************
`define RAM_ACCESS_CLKS 2'h1
`define PIO_ACCESS_CLKS 2'h3
`define STEP_BYTE 8'h01
`define STEP_WORD 8'h02
`define READ_ZERO 32'h0000_0000

`endif

// *** dma6_pkg.sv ***
/*
  types shared by the dma engine files: fsm states, channel state,
  memory access bundle and avalon request bundle.
  assumes dma6_params.svh is on the include path.
*/
`include "dma6_params.svh"
`default_nettype none

package dma6_pkg;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_WAIT_ACK = 3'h1,
    ST_FIRST = 3'h3,
    ST_SECOND = 3'h2,
    ST_UPDATE = 3'h6
  } dma_state_type;

  typedef struct packed {
    logic [15:0] pio_addr;
    logic [15:0] ram_addr;
    logic [7:0] count;
    logic tc;
    logic hold;
    logic [1:0] ttyp;
    logic dir;
    logic size;
    logic en;
  } channel_type;

  typedef struct packed {
    logic rd;
    logic wr;
    logic to_ram;
    logic wide;
    logic [15:0] addr;
    logic [15:0] wdata;
  } mem_req_type;

  typedef struct packed {
    logic read;
    logic write;
    logic [7:0] address;
    logic [3:0] byteenable;
    logic [31:0] writedata;
  } avalon_req_type;

  typedef struct packed {
    channel_type [`NUM_CHANNELS-1:0] ch;
    logic [2:0] trig_exp;
    logic [`NUM_CHANNELS-1:0] pending;
    logic [`NUM_CHANNELS-1:0] irq_status;
    logic [`NUM_CHANNELS-1:0] irq_mask;
    logic [`NUM_CHANNELS-1:0] irq_arm;
    logic [`NUM_CHANNELS-1:0] done_pulse;
    dma_state_type state;
    logic [2:0] cur;
    logic [1:0] phase;
    mem_req_type mem;
    logic bus_ack;
    logic [31:0] rdata;
  } engine_state_type;

endpackage

`default_nettype wire

// *** dma6_priority_pick.sv ***
/*
  fixed priority picker: lowest numbered request wins.
  assumes requests come from the same clock domain.
*/
`include "dma6_params.svh"
`default_nettype none

module dma6_priority_pick
  import dma6_pkg::*;
#(
  parameter int NCH = `NUM_CHANNELS
) (
  // requests
  input wire logic [NCH-1:0] req_in,
  // result
  output logic any_out,
  output logic [2:0] idx_out
);

  always_comb begin
    any_out = |req_in;
    idx_out = 3'h0;
    // walk downward so channel zero overrides everyone
    for (int i = NCH - 1; i >= 0; i--) begin
      if (req_in[i]) begin
        idx_out = 3'(i);
      end
    end
  end

endmodule

`default_nettype wire

// *** dma6_engine.sv ***
/*
  six-channel dma engine between internal ram and peripheral registers,
  with avalon-mm register slave, fixed priority and per-channel done pulses.
  assumes triggers and cpu acknowledge are on CLK_IN, and the memory side
  accepts one access per cycle with read data valid in the last cycle.
*/
// Contract
// - moves run between ram and peripherals, started only by peripheral requests
// - six independent channels, each moving bytes or 16-bit words
// - one programming moves at most 256 bytes
// - every channel has its own completion interrupt output
// - simultaneous requests are served channel zero first, channel five last
// - on completion the done flag sets first, then the interrupt pulse
// - the selected trigger of a channel raises a request to the cpu
// - ram access takes one clock, peripheral access three clocks
// - winning channel supplies addresses, direction and size to the access
// - count drops by 1 or 2 per move, ending on borrow
// - ram address steps 1 or 2 per move unless hold is set
// - writing control clears done flag; enable self-clears on completion
// - direction 0 ram to peripheral, 1 reverse; size 0 byte, 1 word
`include "dma6_params.svh"
`default_nettype none

module dma6_engine
  import dma6_pkg::*;
(
  // clock and reset
  input wire logic CLK_IN,
  input wire logic RESET_N_IN,
  // avalon-mm slave
  input wire avalon_req_type AV_IN,
  output logic [31:0] AV_READDATA_OUT,
  output logic AV_WAITREQUEST_OUT,
  // peripheral trigger lines, one set per channel
  input wire logic [`NUM_CHANNELS-1:0][`TRIG_SOURCES-1:0] TRIG_IN,
  // cpu bus arbitration
  output logic DMA_REQ_OUT,
  input wire logic DMA_ACK_IN,
  // internal bus access
  output mem_req_type MEM_REQ_OUT,
  input wire logic [15:0] MEM_RDATA_IN,
  // interrupts
  output logic [`NUM_CHANNELS-1:0] XFER_DONE_IRQ_OUT,
  output logic IRQ_OUT
);

  localparam int NCH = `NUM_CHANNELS;

  // ****************************************
  // functions
  // ****************************************
  function automatic logic [7:0] ch_addr(input int i, input logic [7:0] ofs);
    ch_addr = 8'(8'(i) * `CH_STRIDE + ofs);
  endfunction

  function automatic logic [2:0] trig_index(input int i, input logic [1:0] ttyp,
                                            input logic [2:0] exp_bits);
    logic e;
    // channel zero has no expansion choice
    e = (i == 0) ? 1'b0 : exp_bits[(i - 1) % 3];
    trig_index = {e, ttyp};
  endfunction

  function automatic logic [7:0] ctrl_pack(input channel_type c);
    logic [7:0] r;
    r = 8'h00;
    r[`CTRL_TC] = c.tc;
    r[`CTRL_HOLD] = c.hold;
    r[`CTRL_TTYP_HI:`CTRL_TTYP_LO] = c.ttyp;
    r[`CTRL_DIR] = c.dir;
    r[`CTRL_SIZE] = c.size;
    r[`CTRL_EN] = c.en;
    ctrl_pack = r;
  endfunction

  function automatic logic [7:0] step_of(input channel_type c);
    step_of = c.size ? `STEP_WORD : `STEP_BYTE;
  endfunction

  function automatic logic [31:0] be_merge(input logic [31:0] old_w,
                                           input logic [31:0] new_w,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old_w;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = new_w[b*8 +: 8];
      end
    end
    be_merge = r;
  endfunction

  function automatic logic [31:0] reg_read(input engine_state_type st,
                                           input logic [7:0] a);
    logic [31:0] r;
    r = `READ_ZERO;
    for (int i = 0; i < NCH; i++) begin
      if (a == ch_addr(i, `OFS_PIO_ADDR)) begin
        r = {16'h0000, st.ch[i].pio_addr};
      end
      if (a == ch_addr(i, `OFS_RAM_ADDR)) begin
        r = {16'h0000, st.ch[i].ram_addr};
      end
      if (a == ch_addr(i, `OFS_COUNT)) begin
        r = {24'h000000, st.ch[i].count};
      end
      if (a == ch_addr(i, `OFS_CTRL)) begin
        r = {24'h000000, ctrl_pack(st.ch[i])};
      end
    end
    if (a == `OFS_TRIG_EXP) begin
      r = {29'h0, st.trig_exp};
    end
    if (a == `OFS_IRQ_STATUS) begin
      r = {{(32 - NCH){1'b0}}, st.irq_status};
    end
    if (a == `OFS_IRQ_MASK) begin
      r = {{(32 - NCH){1'b0}}, st.irq_mask};
    end
    reg_read = r;
  endfunction

  // ****************************************
  // state and helpers
  // ****************************************
  engine_state_type s;
  engine_state_type next_s;
  logic pick_any;
  logic [2:0] pick_idx;
  channel_type pick_ch;
  channel_type cur_ch;
  logic [7:0] step8;
  logic borrow;
  logic bus_req;

  dma6_priority_pick #(
    .NCH(NCH)
  ) dma6_priority_pick_inst (
    .req_in(s.pending),
    .any_out(pick_any),
    .idx_out(pick_idx)
  );

  assign pick_ch = s.ch[pick_idx];
  assign cur_ch = s.ch[s.cur];
  assign step8 = step_of(cur_ch);
  // bit 0 of the count is ignored for word moves
  assign borrow = {cur_ch.count[7:1], cur_ch.count[0] & ~cur_ch.size} < step8;
  assign bus_req = AV_IN.read | AV_IN.write;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    logic [31:0] wd;
    wd = `READ_ZERO;
    next_s = s;
    next_s.done_pulse = s.irq_arm;
    next_s.irq_arm = '0;
    // answer every request after one wait cycle
    next_s.bus_ack = bus_req & ~s.bus_ack;
    if (bus_req & ~s.bus_ack) begin
      next_s.rdata = reg_read(s, AV_IN.address);
    end
    if (AV_IN.write & s.bus_ack) begin
      wd = be_merge(reg_read(s, AV_IN.address), AV_IN.writedata, AV_IN.byteenable);
      for (int i = 0; i < NCH; i++) begin
        if (AV_IN.address == ch_addr(i, `OFS_PIO_ADDR)) begin
          next_s.ch[i].pio_addr = wd[15:0];
        end
        if (AV_IN.address == ch_addr(i, `OFS_RAM_ADDR)) begin
          next_s.ch[i].ram_addr = wd[15:0];
        end
        if (AV_IN.address == ch_addr(i, `OFS_COUNT)) begin
          next_s.ch[i].count = wd[7:0];
        end
        if (AV_IN.address == ch_addr(i, `OFS_CTRL)) begin
          next_s.ch[i].tc = 1'b0;
          next_s.ch[i].hold = wd[`CTRL_HOLD];
          next_s.ch[i].ttyp = wd[`CTRL_TTYP_HI:`CTRL_TTYP_LO];
          next_s.ch[i].dir = wd[`CTRL_DIR];
          next_s.ch[i].size = wd[`CTRL_SIZE];
          next_s.ch[i].en = wd[`CTRL_EN];
        end
      end
      if (AV_IN.address == `OFS_TRIG_EXP) begin
        next_s.trig_exp = wd[2:0];
      end
      if (AV_IN.address == `OFS_IRQ_STATUS) begin
        next_s.irq_status = s.irq_status & ~wd[NCH-1:0];
      end
      if (AV_IN.address == `OFS_IRQ_MASK) begin
        next_s.irq_mask = wd[NCH-1:0];
      end
    end
    // sticky status; a set in the clearing cycle survives
    next_s.irq_status = next_s.irq_status | s.irq_arm;
    // trigger capture
    for (int i = 0; i < NCH; i++) begin
      if (!s.ch[i].en || !next_s.ch[i].en) begin
        next_s.pending[i] = 1'b0;
      end else if (TRIG_IN[i][trig_index(i, s.ch[i].ttyp, s.trig_exp)]) begin
        next_s.pending[i] = 1'b1;
      end
    end
    unique case (s.state)
      ST_IDLE: begin
        if (pick_any) begin
          next_s.state = ST_WAIT_ACK;
        end
      end
      ST_WAIT_ACK: begin
        if (!pick_any) begin
          next_s.state = ST_IDLE;
        end else if (DMA_ACK_IN) begin
          next_s.cur = pick_idx;
          next_s.pending[pick_idx] = 1'b0;
          next_s.mem.rd = 1'b1;
          next_s.mem.wr = 1'b0;
          next_s.mem.to_ram = ~pick_ch.dir;
          next_s.mem.wide = pick_ch.size;
          next_s.mem.addr = pick_ch.dir ? pick_ch.pio_addr : pick_ch.ram_addr;
          next_s.mem.wdata = 16'h0000;
          next_s.phase = pick_ch.dir ? 2'(`PIO_ACCESS_CLKS - 2'h1)
                                     : 2'(`RAM_ACCESS_CLKS - 2'h1);
          next_s.state = ST_FIRST;
        end
      end
      ST_FIRST: begin
        if (s.phase == 2'h0) begin
          next_s.mem.rd = 1'b0;
          next_s.mem.wr = 1'b1;
          next_s.mem.to_ram = cur_ch.dir;
          next_s.mem.addr = cur_ch.dir ? cur_ch.ram_addr : cur_ch.pio_addr;
          next_s.mem.wdata = MEM_RDATA_IN;
          next_s.phase = cur_ch.dir ? 2'(`RAM_ACCESS_CLKS - 2'h1)
                                    : 2'(`PIO_ACCESS_CLKS - 2'h1);
          next_s.state = ST_SECOND;
        end else begin
          next_s.phase = 2'(s.phase - 2'h1);
        end
      end
      ST_SECOND: begin
        if (s.phase == 2'h0) begin
          next_s.mem = '0;
          next_s.state = ST_UPDATE;
        end else begin
          next_s.phase = 2'(s.phase - 2'h1);
        end
      end
      ST_UPDATE: begin
        // count of 8 bits: 0xff in byte mode gives 256 moves
        if (borrow) begin
          next_s.ch[s.cur].tc = 1'b1;
          next_s.ch[s.cur].en = 1'b0;
          next_s.pending[s.cur] = 1'b0;
          next_s.irq_arm[s.cur] = 1'b1;
        end
        next_s.ch[s.cur].count = 8'(cur_ch.count - step8);
        if (!cur_ch.hold) begin
          next_s.ch[s.cur].ram_addr = 16'(cur_ch.ram_addr + {8'h00, step8});
        end
        next_s.state = ST_IDLE;
      end
      default: begin
        next_s.state = ST_IDLE;
      end
    endcase
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge CLK_IN) begin
    if (!RESET_N_IN) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign AV_READDATA_OUT = s.rdata;
  assign AV_WAITREQUEST_OUT = bus_req & ~s.bus_ack;
  assign DMA_REQ_OUT = (s.state == ST_WAIT_ACK) & pick_any;
  assign MEM_REQ_OUT = s.mem;
  assign XFER_DONE_IRQ_OUT = s.done_pulse;
  assign IRQ_OUT = |(s.irq_status & s.irq_mask);

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (!RESET_N_IN);

  logic [NCH-1:0] en_vec;
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      en_vec[i] = s.ch[i].en;
    end
  end

  chk_req_has_cause: assert property (DMA_REQ_OUT |-> $past(s.pending != '0))
    else $error("cpu request without a pending trigger");

  chk_disabled_no_pend: assert property (1'b1 |=> ((s.pending & ~$past(en_vec)) == '0))
    else $error("disabled channel holds a pending request");

  chk_priority_pick: assert property ((s.state == ST_WAIT_ACK && DMA_ACK_IN && pick_any)
      |=> (s.cur == $past(pick_idx)) && (($past(s.pending) & ((6'h01 << s.cur) - 6'h01)) == '0))
    else $error("granted channel is not the lowest pending one");

  chk_first_address: assert property ((s.state == ST_FIRST && $past(s.state) == ST_WAIT_ACK)
      |-> s.mem.addr == (cur_ch.dir ? cur_ch.pio_addr : cur_ch.ram_addr))
    else $error("first access uses wrong address");

  chk_direction_map: assert property ((s.state == ST_FIRST && $past(s.state) == ST_WAIT_ACK)
      |-> s.mem.rd && (s.mem.to_ram == !cur_ch.dir) && (s.mem.wide == cur_ch.size))
    else $error("first access direction or size wrong");

  chk_ram_one_clock: assert property ((s.state == ST_FIRST && $past(s.state) == ST_WAIT_ACK
      && s.mem.to_ram) |=> s.state == ST_SECOND)
    else $error("ram access is not one clock");

  chk_pio_three_clocks: assert property ((s.state == ST_SECOND && $past(s.state) == ST_FIRST
      && !s.mem.to_ram) |-> (s.state == ST_SECOND)[*3] ##1 (s.state == ST_UPDATE))
    else $error("peripheral access is not three clocks");

  chk_done_order: assert property ((s.state == ST_UPDATE && borrow)
      |=> s.ch[$past(s.cur)].tc && !s.ch[$past(s.cur)].en && (XFER_DONE_IRQ_OUT == '0)
      ##1 XFER_DONE_IRQ_OUT[$past(s.cur, 2)])
    else $error("done flag and interrupt out of order");

  chk_count_step: assert property ((s.state == ST_UPDATE)
      |=> s.ch[$past(s.cur)].count == 8'($past(cur_ch.count) - $past(step8)))
    else $error("count did not drop by the move size");

  chk_addr_advance: assert property ((s.state == ST_UPDATE)
      |=> s.ch[$past(s.cur)].ram_addr == ($past(cur_ch.hold) ? $past(cur_ch.ram_addr)
          : 16'($past(cur_ch.ram_addr) + {8'h00, $past(step8)})))
    else $error("ram address step wrong");

endmodule

`default_nettype wire

// *** dma6_partner.sv ***
/*
  stand-in for the cpu bus arbiter and the internal memory seen by the dma engine.
  assumes one clock shared with the engine and a synchronous active-low reset.
*/
`include "dma6_params.svh"
`default_nettype none

module dma6_partner
  import dma6_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // cpu arbitration
  input wire logic req_in,
  input wire logic [3:0] delay_in,
  output logic ack_out,
  // memory
  input wire mem_req_type mem_in,
  output logic [15:0] rdata_out
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [3:0] wait_cnt;
  logic [15:0] last;

  // ****************************************
  // cpu acknowledge
  // ****************************************
  // the cpu finishes its own work first, modelled as delay_in cycles
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      ack_out <= 1'b0;
      wait_cnt <= 4'h0;
    end else if (req_in && !ack_out) begin
      if (wait_cnt >= delay_in) begin
        ack_out <= 1'b1;
      end else begin
        wait_cnt <= wait_cnt + 4'h1;
      end
    end else begin
      ack_out <= 1'b0;
      wait_cnt <= 4'h0;
    end
  end

  // ****************************************
  // memory read data
  // ****************************************
  // idle data lines show the inverse, so a stale capture never passes
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      last <= 16'h0000;
    end else if (mem_in.rd) begin
      last <= mem_in.addr ^ 16'h5a3c;
    end
  end
  assign rdata_out = mem_in.rd ? (mem_in.addr ^ 16'h5a3c) : ~last;
endmodule

`default_nettype wire

// *** six_channel_peripheral_dma_tb.sv ***
/*
  self-checking bench for the six-channel dma engine: register tasks, triggers, access log.
  assumes dma6_pkg, dma6_engine and dma6_partner are compiled first.
*/
`include "dma6_params.svh"
`default_nettype none

module six_channel_peripheral_dma_tb
  import dma6_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk;
  logic reset_n;
  avalon_req_type av;
  logic [31:0] rdata;
  logic waitreq;
  logic [`NUM_CHANNELS-1:0][`TRIG_SOURCES-1:0] trig;
  logic dma_req;
  logic dma_ack;
  logic [3:0] ack_delay;
  mem_req_type mem;
  logic [15:0] mem_rdata;
  logic [`NUM_CHANNELS-1:0] done_irq;
  logic irq;
  logic req_seen;
  mem_req_type acc_log[$];
  int done_cnt[`NUM_CHANNELS];
  int num_errors;
  int total_checks;
  int cycles;
  logic [31:0] q;

  dma6_engine dma6_engine_inst (.CLK_IN(clk), .RESET_N_IN(reset_n), .AV_IN(av), .AV_READDATA_OUT(rdata),
    .AV_WAITREQUEST_OUT(waitreq), .TRIG_IN(trig), .DMA_REQ_OUT(dma_req), .DMA_ACK_IN(dma_ack),
    .MEM_REQ_OUT(mem), .MEM_RDATA_IN(mem_rdata), .XFER_DONE_IRQ_OUT(done_irq), .IRQ_OUT(irq));
  dma6_partner dma6_partner_inst (.clk_in(clk), .reset_n_in(reset_n), .req_in(dma_req), .delay_in(ack_delay),
    .ack_out(dma_ack), .mem_in(mem), .rdata_out(mem_rdata));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ****************************************
  // monitors
  // ****************************************
  // sampled mid-cycle so registered outputs have settled
  always @(negedge clk) begin
    if (mem.rd | mem.wr) acc_log.push_back(mem);
    if (dma_req === 1'b1) req_seen = 1'b1;
    for (int c = 0; c < `NUM_CHANNELS; c++) if (done_irq[c] === 1'b1) done_cnt[c]++;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      close_out();
    end
  end

  // ****************************************
  // tasks
  // ****************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // waitrequest and read data are taken at the rising edge, before that edge updates them
  task automatic av_xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    av.read <= ~wr;
    av.write <= wr;
    av.address <= a;
    av.writedata <= d;
    av.byteenable <= 4'hf;
    do begin
      @(posedge clk);
    end while (waitreq !== 1'b0);
    q = rdata;
    av.read <= 1'b0;
    av.write <= 1'b0;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    av_xfer(1'b1, a, d);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    av_xfer(1'b0, a, 32'h0);
    chk(q, e);
  endtask

  task automatic setup(input logic [7:0] b, input logic [15:0] pio, input logic [15:0] ram,
                       input logic [7:0] cnt, input logic [7:0] ctl);
    wr_reg(b + `OFS_PIO_ADDR, {16'h0, pio});
    wr_reg(b + `OFS_RAM_ADDR, {16'h0, ram});
    wr_reg(b + `OFS_COUNT, {24'h0, cnt});
    wr_reg(b + `OFS_CTRL, {24'h0, ctl});
  endtask

  task automatic pulse(input logic [47:0] bits);
    @(posedge clk);
    trig <= bits;
    @(posedge clk);
    trig <= '0;
  endtask

  // settle covers the update and done pulse cycles after the last access
  // a move that never comes is caught by the cycle ceiling
  task automatic wait_moves(input int target);
    while (acc_log.size() < target) begin
      @(negedge clk);
    end
    repeat (6) @(negedge clk);
  endtask

  task automatic chk_move(input int b, input logic dir, input logic wide, input logic [15:0] ram,
                          input logic [15:0] pio);
    mem_req_type m;
    logic first;
    logic to_ram;
    logic [15:0] msk;
    msk = wide ? 16'hffff : 16'h00ff;
    for (int k = 0; k < 4; k++) begin
      m = acc_log[b + k];
      first = dir ? (k < 3) : (k < 1);
      to_ram = first ^ dir;
      chk({13'h0, m.rd, m.wr, m.to_ram, m.addr}, {13'h0, first, ~first, to_ram, to_ram ? ram : pio});
      chk({31'h0, m.wide}, {31'h0, wide});
    end
    m = acc_log[b + (dir ? 3 : 1)];
    chk({16'h0, m.wdata & msk}, {16'h0, ((dir ? pio : ram) ^ 16'h5a3c) & msk});
  endtask

  task automatic chk_irq(input logic e);
    repeat (2) @(negedge clk);
    chk({31'h0, irq}, {31'h0, e});
  endtask

  task close_out;
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ****************************************
  // tests
  // ****************************************
  initial begin
    num_errors = 0;
    total_checks = 0;
    cycles = 0;
    req_seen = 1'b0;
    reset_n = 1'b0;
    av = '0;
    trig = '0;
    ack_delay = 4'h0;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    rd_chk(`OFS_CTRL, 32'h0);
    rd_chk(8'h50 + `OFS_COUNT, 32'h0);
    rd_chk(8'h50 + `OFS_RAM_ADDR, 32'h0);
    rd_chk(`OFS_IRQ_STATUS, 32'h0);
    rd_chk(8'h70, 32'h0);
    $display("test reset values done");
    setup(8'h10, 16'h0010, 16'h0200, 8'h00, 8'h00);
    pulse(48'h1 << 8);
    repeat (8) @(negedge clk);
    chk({31'h0, req_seen}, 32'h0);
    chk(32'(acc_log.size()), 32'h0);
    $display("test disabled channel done");
    wr_reg(`OFS_IRQ_MASK, 32'h01);
    setup(8'h00, 16'h0040, 16'h0100, 8'h01, 8'h19);
    pulse(48'h1 << 3);
    wait_moves(4);
    chk_move(0, 1'b0, 1'b0, 16'h0100, 16'h0040);
    chk(32'(done_cnt[0]), 32'h0);
    pulse(48'h1 << 3);
    wait_moves(8);
    chk_move(4, 1'b0, 1'b0, 16'h0101, 16'h0040);
    chk(32'(done_cnt[0]), 32'h1);
    rd_chk(`OFS_COUNT, 32'hff);
    rd_chk(`OFS_RAM_ADDR, 32'h0102);
    rd_chk(`OFS_CTRL, 32'h98);
    rd_chk(`OFS_IRQ_STATUS, 32'h01);
    chk_irq(1'b1);
    pulse(48'h1 << 3);
    repeat (16) @(negedge clk);
    chk(32'(acc_log.size()), 32'h8);
    wr_reg(`OFS_IRQ_STATUS, 32'h01);
    chk_irq(1'b0);
    wr_reg(`OFS_CTRL, 32'h18);
    rd_chk(`OFS_CTRL, 32'h18);
    $display("test byte moves done");
    ack_delay <= 4'h3;
    wr_reg(`OFS_TRIG_EXP, 32'h2);
    setup(8'h20, 16'h0060, 16'h0300, 8'h00, 8'h2f);
    pulse(48'h1 << 21);
    wait_moves(12);
    chk_move(8, 1'b1, 1'b1, 16'h0300, 16'h0060);
    rd_chk(8'h20 + `OFS_RAM_ADDR, 32'h0300);
    rd_chk(8'h20 + `OFS_COUNT, 32'hfe);
    rd_chk(8'h20 + `OFS_CTRL, 32'hae);
    chk_irq(1'b0);
    wr_reg(`OFS_IRQ_MASK, 32'h04);
    chk_irq(1'b1);
    wr_reg(`OFS_IRQ_STATUS, 32'h04);
    chk_irq(1'b0);
    $display("test word moves done");
    ack_delay <= 4'h0;
    setup(8'h30, 16'h0070, 16'h0400, 8'h00, 8'h01);
    setup(8'h40, 16'h0080, 16'h0500, 8'h00, 8'h01);
    pulse((48'h1 << 24) | (48'h1 << 32));
    wait_moves(20);
    chk_move(12, 1'b0, 1'b0, 16'h0400, 16'h0070);
    chk_move(16, 1'b0, 1'b0, 16'h0500, 16'h0080);
    chk(32'(done_cnt[3]), 32'h1);
    chk(32'(done_cnt[4]), 32'h1);
    $display("test priority done");
    setup(8'h50, 16'h0090, 16'h0600, 8'hff, 8'h21);
    for (int i = 0; i < 256; i++) begin
      pulse(48'h1 << 44);
      wait_moves(24 + 4 * i);
      if (i == 254) chk(32'(done_cnt[5]), 32'h0);
    end
    chk(32'(done_cnt[5]), 32'h1);
    chk(32'(acc_log.size()), 32'd1044);
    rd_chk(8'h50 + `OFS_RAM_ADDR, 32'h0600);
    $display("test full count done");
    close_out();
  end
endmodule

`default_nettype wire
